// ---- hdl/cio_core.sv ----
/*
 * Decode and execute core for control flow, inherent and indirect pointer
 * operations, plus literal AND/add and file AND.
 * Assumes program memory returns the word at progAddr in the same cycle and
 * data memory returns read data combinationally for dataAddr.
 */
// How it works
// - PC change costs one extra flushed cycle
// - Indirect access with pointer MSb stalls once
// - Decode both relative branches and absolute jump
// - Decode calls by accumulator and by literal
// - Interrupt exit returns, two cycles
// - Plain return pops stack, two cycles
// - Literal return loads accumulator then returns
// - Sleep and watchdog kick set status flags
// - Option load, software reset, no-op decode
// - Accumulator to selected port direction register
// - Add literal to chosen pointer, no flags
// - Literal is signed six bits, 16-bit add
// - Pointers wrap modulo sixteen bits
// - Modified indirect read to accumulator, zero flag
// - Indexed indirect read to accumulator, zero flag
// - Modified indirect write, flags untouched
// - Indexed indirect write, flags untouched
// - AND literal into accumulator, zero flag
// - Add literal, carry, digit carry, zero
// - AND with file, destination bit chooses
// - Modify: bits 1:0 mode, bit 2 pointer select; index and add select by bit 6
`timescale 1ns/100ps
module cio_core
    import cio_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Program memory
    output logic [14:0] progAddr,
    input wire logic [13:0] progData,
    // Data memory
    output logic [15:0] dataAddr,
    output logic dataRdEn,
    output logic dataWrEn,
    output logic [7:0] dataWrData,
    input wire logic [7:0] dataRdData,
    // Power and system events
    input wire logic wakeUp,
    output logic sleeping,
    output logic watchdogKick,
    output logic softReset,
    output logic intEnable,
    // Core state
    output logic [7:0] accValue,
    output logic carryFlag,
    output logic digitCarryFlag,
    output logic zeroFlag,
    output logic timeoutFlag,
    output logic powerdownFlag,
    output logic [7:0] optionValue,
    output logic [7:0][7:0] portDirection,
    output logic [15:0] ptr0Value,
    output logic [15:0] ptr1Value
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    cio_core_if link ();

    cio_core_s stFf;
    cio_core_s nxtSt;

    cio_op_e op;
    logic [13:0] ins;
    logic [14:0] pcInc;
    logic [7:0] lit;
    logic indirect;
    logic [15:0] selPtr;
    logic needExtra;
    logic doExec;
    logic [8:0] sum;
    logic [4:0] nibSum;
    logic [7:0] result;

    ////////////////////////////////////////////////////////////////////////
    // Submodules
    cio_ptr_unit u_ptr (
        .bus(link.ptr)
    );

    cio_stack u_stack (
        .sys_clk(sys_clk),
        .rst(rst),
        .bus(link.stk)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode and pointer setup
    always_comb begin
        ins = progData;
        op = cio_decode(ins);
        lit = ins[7:0];
        pcInc = stFf.pc + 15'h0001;
        link.ptr0 = stFf.ptr0;
        link.ptr1 = stFf.ptr1;
        link.ptrOp = PTR_NONE;
        link.ptrSel = 1'b0;
        link.ptrMode = ins[1:0];
        link.ptrOffset = ins[5:0];
        indirect = 1'b0;
        case (op)
            OP_RD_MODIFY, OP_WR_MODIFY: begin
                link.ptrOp = PTR_MODIFY;
                link.ptrSel = ins[2];
                indirect = 1'b1;
            end
            OP_RD_INDEX, OP_WR_INDEX: begin
                link.ptrOp = PTR_INDEX;
                link.ptrSel = ins[6];
                indirect = 1'b1;
            end
            OP_PTR_ADD: begin
                link.ptrOp = PTR_ADD;
                link.ptrSel = ins[6];
            end
            OP_AND_FILE: begin
                if (ins[6:1] == 6'h00) begin
                    link.ptrOp = PTR_INDEX;
                    link.ptrSel = ins[0];
                    link.ptrOffset = 6'h00;
                    indirect = 1'b1;
                end
            end
            default: begin
                link.ptrOp = PTR_NONE;
            end
        endcase
        selPtr = link.ptrSel ? stFf.ptr1 : stFf.ptr0;
        needExtra = indirect && selPtr[15];
    end

    ////////////////////////////////////////////////////////////////////////
    // Execute
    always_comb begin
        nxtSt = stFf;
        nxtSt.kick = 1'b0;
        nxtSt.swReset = 1'b0;
        link.stkPush = 1'b0;
        link.stkPop = 1'b0;
        link.stkPushData = pcInc;
        dataAddr = indirect ? link.ptrAddr : {9'h000, ins[6:0]};
        dataRdEn = 1'b0;
        dataWrEn = 1'b0;
        dataWrData = stFf.acc;
        sum = {1'b0, stFf.acc} + {1'b0, lit};
        nibSum = {1'b0, stFf.acc[3:0]} + {1'b0, lit[3:0]};
        result = stFf.acc & dataRdData;
        doExec = 1'b0;

        case (stFf.phase)
            PH_FLUSH: begin
                nxtSt.phase = PH_EXEC;
            end
            PH_SLEEP: begin
                if (wakeUp) begin
                    nxtSt.phase = PH_EXEC;
                end
            end
            PH_EXEC: begin
                if (needExtra) begin
                    nxtSt.phase = PH_STALL;
                end else begin
                    doExec = 1'b1;
                end
            end
            PH_STALL: begin
                nxtSt.phase = PH_EXEC;
                doExec = 1'b1;
            end
            default: begin
                nxtSt.phase = PH_EXEC;
            end
        endcase

        if (doExec) begin
            nxtSt.pc = pcInc;
            case (op)
                OP_REL_LIT: begin
                    nxtSt.pc = pcInc + {{6{ins[8]}}, ins[8:0]};
                    nxtSt.phase = PH_FLUSH;
                end
                OP_REL_ACC: begin
                    nxtSt.pc = pcInc + {7'h00, stFf.acc};
                    nxtSt.phase = PH_FLUSH;
                end
                OP_JUMP: begin
                    nxtSt.pc = {stFf.pc[14:11], ins[10:0]};
                    nxtSt.phase = PH_FLUSH;
                end
                OP_CALL: begin
                    link.stkPush = 1'b1;
                    nxtSt.pc = {stFf.pc[14:11], ins[10:0]};
                    nxtSt.phase = PH_FLUSH;
                end
                OP_CALL_ACC: begin
                    link.stkPush = 1'b1;
                    nxtSt.pc = {stFf.pc[14:8], stFf.acc};
                    nxtSt.phase = PH_FLUSH;
                end
                OP_INT_EXIT: begin
                    link.stkPop = 1'b1;
                    nxtSt.pc = link.stkTop;
                    nxtSt.intEnable = 1'b1;
                    nxtSt.phase = PH_FLUSH;
                end
                OP_RETURN: begin
                    link.stkPop = 1'b1;
                    nxtSt.pc = link.stkTop;
                    nxtSt.phase = PH_FLUSH;
                end
                OP_LIT_RETURN: begin
                    link.stkPop = 1'b1;
                    nxtSt.acc = lit;
                    nxtSt.pc = link.stkTop;
                    nxtSt.phase = PH_FLUSH;
                end
                OP_KICK: begin
                    nxtSt.kick = 1'b1;
                    nxtSt.timeoutFlag = 1'b1;
                    nxtSt.powerdownFlag = 1'b1;
                end
                OP_SLEEP: begin
                    nxtSt.timeoutFlag = 1'b1;
                    nxtSt.powerdownFlag = 1'b0;
                    nxtSt.kick = 1'b1;
                    nxtSt.phase = PH_SLEEP;
                end
                OP_OPTION: begin
                    nxtSt.option = stFf.acc;
                end
                OP_SW_RESET: begin
                    nxtSt.swReset = 1'b1;
                end
                OP_PORT_DIR: begin
                    nxtSt.portDir[ins[2:0]] = stFf.acc;
                end
                OP_PTR_ADD: begin
                    if (ins[6]) begin
                        nxtSt.ptr1 = link.ptrNext;
                    end else begin
                        nxtSt.ptr0 = link.ptrNext;
                    end
                end
                OP_RD_MODIFY: begin
                    dataRdEn = 1'b1;
                    nxtSt.acc = dataRdData;
                    nxtSt.zero = (dataRdData == 8'h00);
                    if (ins[2]) begin
                        nxtSt.ptr1 = link.ptrNext;
                    end else begin
                        nxtSt.ptr0 = link.ptrNext;
                    end
                end
                OP_RD_INDEX: begin
                    dataRdEn = 1'b1;
                    nxtSt.acc = dataRdData;
                    nxtSt.zero = (dataRdData == 8'h00);
                end
                OP_WR_MODIFY: begin
                    dataWrEn = 1'b1;
                    if (ins[2]) begin
                        nxtSt.ptr1 = link.ptrNext;
                    end else begin
                        nxtSt.ptr0 = link.ptrNext;
                    end
                end
                OP_WR_INDEX: begin
                    dataWrEn = 1'b1;
                end
                OP_AND_LIT: begin
                    nxtSt.acc = stFf.acc & lit;
                    nxtSt.zero = ((stFf.acc & lit) == 8'h00);
                end
                OP_ADD_LIT: begin
                    nxtSt.acc = sum[7:0];
                    nxtSt.carry = sum[8];
                    nxtSt.digitCarry = nibSum[4];
                    nxtSt.zero = (sum[7:0] == 8'h00);
                end
                OP_AND_FILE: begin
                    dataRdEn = 1'b1;
                    nxtSt.zero = (result == 8'h00);
                    if (ins[7]) begin
                        dataWrEn = 1'b1;
                        dataWrData = result;
                    end else begin
                        nxtSt.acc = result;
                    end
                end
                default: begin
                    nxtSt.pc = pcInc;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stFf.phase <= PH_EXEC;
            stFf.pc <= PC_RESET;
            stFf.acc <= ACC_RESET;
            stFf.carry <= 1'b0;
            stFf.digitCarry <= 1'b0;
            stFf.zero <= 1'b0;
            stFf.timeoutFlag <= 1'b1;
            stFf.powerdownFlag <= 1'b1;
            stFf.option <= OPTION_RESET;
            stFf.portDir <= {8{PORT_DIR_RESET}};
            stFf.ptr0 <= PTR_RESET;
            stFf.ptr1 <= PTR_RESET;
            stFf.kick <= 1'b0;
            stFf.swReset <= 1'b0;
            stFf.intEnable <= 1'b0;
        end else begin
            stFf <= nxtSt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign progAddr = stFf.pc;
    assign sleeping = (stFf.phase == PH_SLEEP);
    assign watchdogKick = stFf.kick;
    assign softReset = stFf.swReset;
    assign intEnable = stFf.intEnable;
    assign accValue = stFf.acc;
    assign carryFlag = stFf.carry;
    assign digitCarryFlag = stFf.digitCarry;
    assign zeroFlag = stFf.zero;
    assign timeoutFlag = stFf.timeoutFlag;
    assign powerdownFlag = stFf.powerdownFlag;
    assign optionValue = stFf.option;
    assign portDirection = stFf.portDir;
    assign ptr0Value = stFf.ptr0;
    assign ptr1Value = stFf.ptr1;

endmodule // cio_core

// ---- shared/cio_pkg.sv ----
/*
 * Package for the control and indirect operation core: opcodes, decode,
 * state types and reset values.
 * Assumes 14-bit instruction words and an 8-bit accumulator datapath.
 */
package cio_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths and sizes
    localparam int PC_W = 15;
    localparam int STK_DEPTH = 16;
    localparam int STK_PTR_W = 4;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [14:0] PC_RESET = 15'h0000;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] OPTION_RESET = 8'hFF;
    localparam logic [7:0] PORT_DIR_RESET = 8'hFF;
    localparam logic [15:0] PTR_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Exact opcodes
    localparam logic [13:0] OPC_NOP = 14'h0000;
    localparam logic [13:0] OPC_SW_RESET = 14'h0001;
    localparam logic [13:0] OPC_RETURN = 14'h0008;
    localparam logic [13:0] OPC_INT_EXIT = 14'h0009;
    localparam logic [13:0] OPC_CALL_ACC = 14'h000A;
    localparam logic [13:0] OPC_REL_ACC = 14'h000B;
    localparam logic [13:0] OPC_OPTION = 14'h0062;
    localparam logic [13:0] OPC_SLEEP = 14'h0063;
    localparam logic [13:0] OPC_KICK = 14'h0064;

    // Patterned opcodes: value and mask
    localparam logic [13:0] OPC_PORT_DIR = 14'h0060;
    localparam logic [13:0] MSK_PORT_DIR = 14'h3FF8;
    localparam logic [13:0] OPC_REL_LIT = 14'h3200;
    localparam logic [13:0] MSK_REL_LIT = 14'h3E00;
    localparam logic [13:0] OPC_CALL = 14'h2000;
    localparam logic [13:0] OPC_JUMP = 14'h2800;
    localparam logic [13:0] MSK_JUMP = 14'h3800;
    localparam logic [13:0] OPC_LIT_RETURN = 14'h3400;
    localparam logic [13:0] OPC_AND_LIT = 14'h3900;
    localparam logic [13:0] OPC_ADD_LIT = 14'h3E00;
    localparam logic [13:0] OPC_AND_FILE = 14'h0500;
    localparam logic [13:0] MSK_BYTE_OP = 14'h3F00;
    localparam logic [13:0] OPC_PTR_ADD = 14'h3100;
    localparam logic [13:0] OPC_RD_INDEX = 14'h3F00;
    localparam logic [13:0] OPC_WR_INDEX = 14'h3F80;
    localparam logic [13:0] MSK_INDEX = 14'h3F80;
    localparam logic [13:0] OPC_RD_MODIFY = 14'h0010;
    localparam logic [13:0] OPC_WR_MODIFY = 14'h0018;
    localparam logic [13:0] MSK_MODIFY = 14'h3FF8;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [4:0] {
        OP_NOP, OP_REL_LIT, OP_REL_ACC, OP_CALL, OP_CALL_ACC, OP_JUMP,
        OP_INT_EXIT, OP_LIT_RETURN, OP_RETURN, OP_KICK, OP_OPTION,
        OP_SW_RESET, OP_SLEEP, OP_PORT_DIR, OP_PTR_ADD, OP_RD_MODIFY,
        OP_RD_INDEX, OP_WR_MODIFY, OP_WR_INDEX, OP_AND_LIT, OP_ADD_LIT,
        OP_AND_FILE, OP_OTHER
    } cio_op_e;

    typedef enum logic [1:0] {PTR_NONE, PTR_MODIFY, PTR_INDEX, PTR_ADD} cio_ptr_op_e;

    typedef enum logic [1:0] {PH_EXEC, PH_STALL, PH_FLUSH, PH_SLEEP} cio_phase_e;

    typedef struct packed {
        cio_phase_e phase;
        logic [14:0] pc;
        logic [7:0] acc;
        logic carry;
        logic digitCarry;
        logic zero;
        logic timeoutFlag;
        logic powerdownFlag;
        logic [7:0] option;
        logic [7:0][7:0] portDir;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic kick;
        logic swReset;
        logic intEnable;
    } cio_core_s;

    ////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic [15:0] cio_sext6(input logic [5:0] k);
        return {{10{k[5]}}, k};
    endfunction

    function automatic logic cio_match(input logic [13:0] ins, input logic [13:0] val,
                                       input logic [13:0] msk);
        return (ins & msk) == val;
    endfunction

    function automatic cio_op_e cio_decode(input logic [13:0] ins);
        cio_op_e op;
        op = OP_OTHER;
        if (ins == OPC_NOP) op = OP_NOP;
        else if (ins == OPC_SW_RESET) op = OP_SW_RESET;
        else if (ins == OPC_RETURN) op = OP_RETURN;
        else if (ins == OPC_INT_EXIT) op = OP_INT_EXIT;
        else if (ins == OPC_CALL_ACC) op = OP_CALL_ACC;
        else if (ins == OPC_REL_ACC) op = OP_REL_ACC;
        else if (ins == OPC_OPTION) op = OP_OPTION;
        else if (ins == OPC_SLEEP) op = OP_SLEEP;
        else if (ins == OPC_KICK) op = OP_KICK;
        else if (cio_match(ins, OPC_PORT_DIR, MSK_PORT_DIR)) op = OP_PORT_DIR;
        else if (cio_match(ins, OPC_RD_MODIFY, MSK_MODIFY)) op = OP_RD_MODIFY;
        else if (cio_match(ins, OPC_WR_MODIFY, MSK_MODIFY)) op = OP_WR_MODIFY;
        else if (cio_match(ins, OPC_REL_LIT, MSK_REL_LIT)) op = OP_REL_LIT;
        else if (cio_match(ins, OPC_CALL, MSK_JUMP)) op = OP_CALL;
        else if (cio_match(ins, OPC_JUMP, MSK_JUMP)) op = OP_JUMP;
        else if (cio_match(ins, OPC_LIT_RETURN, MSK_BYTE_OP)) op = OP_LIT_RETURN;
        else if (cio_match(ins, OPC_PTR_ADD, MSK_INDEX)) op = OP_PTR_ADD;
        else if (cio_match(ins, OPC_RD_INDEX, MSK_INDEX)) op = OP_RD_INDEX;
        else if (cio_match(ins, OPC_WR_INDEX, MSK_INDEX)) op = OP_WR_INDEX;
        else if (cio_match(ins, OPC_AND_LIT, MSK_BYTE_OP)) op = OP_AND_LIT;
        else if (cio_match(ins, OPC_ADD_LIT, MSK_BYTE_OP)) op = OP_ADD_LIT;
        else if (cio_match(ins, OPC_AND_FILE, MSK_BYTE_OP)) op = OP_AND_FILE;
        return op;
    endfunction

endpackage

// ---- shared/cio_core_if.sv ----
/*
 * Carrier between the core, its pointer arithmetic unit and its return stack.
 * Assumes all three parties run on one clock.
 */
`timescale 1ns/100ps
interface cio_core_if;
    import cio_pkg::*;
    cio_ptr_op_e ptrOp;
    logic ptrSel;
    logic [1:0] ptrMode;
    logic [5:0] ptrOffset;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [15:0] ptrAddr;
    logic [15:0] ptrNext;
    logic stkPush;
    logic stkPop;
    logic [14:0] stkPushData;
    logic [14:0] stkTop;

    modport core (output ptrOp, ptrSel, ptrMode, ptrOffset, ptr0, ptr1, stkPush, stkPop, stkPushData,
                  input ptrAddr, ptrNext, stkTop);
    modport ptr (input ptrOp, ptrSel, ptrMode, ptrOffset, ptr0, ptr1, output ptrAddr, ptrNext);
    modport stk (input stkPush, stkPop, stkPushData, output stkTop);
endinterface

// ---- hdl/cio_ptr_unit.sv ----
/*
 * Pointer arithmetic: access address and updated pointer value.
 * Assumes the core holds both pointers and applies the update.
 */
`timescale 1ns/100ps
module cio_ptr_unit
    import cio_pkg::*;
(
    // Core side
    cio_core_if.ptr bus
);
    logic [15:0] sel;
    logic [15:0] step;

    always_comb begin
        sel = bus.ptrSel ? bus.ptr1 : bus.ptr0;
        step = bus.ptrMode[0] ? 16'hFFFF : 16'h0001;
        bus.ptrAddr = sel;
        bus.ptrNext = sel;
        case (bus.ptrOp)
            PTR_MODIFY: begin
                bus.ptrNext = sel + step;
                bus.ptrAddr = bus.ptrMode[1] ? sel : sel + step;
            end
            PTR_INDEX: begin
                bus.ptrAddr = sel + cio_sext6(bus.ptrOffset);
            end
            PTR_ADD: begin
                bus.ptrNext = sel + cio_sext6(bus.ptrOffset);
            end
            default: begin
                bus.ptrNext = sel;
            end
        endcase
    end
endmodule // cio_ptr_unit

// ---- hdl/cio_stack.sv ----
/*
 * Return address stack, wrapping on overflow and underflow.
 * Assumes the core never pushes and pops in one cycle.
 */
`timescale 1ns/100ps
module cio_stack
    import cio_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Core side
    cio_core_if.stk bus
);
    typedef struct packed {
        logic [STK_DEPTH-1:0][14:0] mem;
        logic [STK_PTR_W-1:0] sp;
    } cio_stack_s;

    cio_stack_s stFf;
    cio_stack_s nxtSt;

    always_comb begin
        nxtSt = stFf;
        if (bus.stkPush) begin
            nxtSt.mem[stFf.sp] = bus.stkPushData;
            nxtSt.sp = stFf.sp + 4'h1;
        end else if (bus.stkPop) begin
            nxtSt.sp = stFf.sp - 4'h1;
        end
    end

    assign bus.stkTop = stFf.mem[stFf.sp - 4'h1];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stFf <= '0;
        end else begin
            stFf <= nxtSt;
        end
    end
endmodule // cio_stack

// ---- sim/cio_core_asserts.sv ----
/*
 * Port checker for cio_core.
 * Assumes one clock and a synchronous active-high rst.
 */
`timescale 1ns/100ps
module cio_core_asserts
    import cio_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Watched ports
    input wire logic [14:0] progAddr,
    input wire logic [13:0] progData,
    input wire logic dataWrEn,
    input wire logic sleeping,
    input wire logic watchdogKick,
    input wire logic intEnable,
    input wire logic [7:0] accValue,
    input wire logic carryFlag,
    input wire logic zeroFlag,
    input wire logic timeoutFlag,
    input wire logic powerdownFlag,
    input wire logic [7:0] optionValue,
    input wire logic [7:0][7:0] portDirection,
    input wire logic [15:0] ptr0Value
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [14:0] prevAddr_ff;
    logic [13:0] prevData_ff;
    logic live;
    always_ff @(posedge sys_clk) begin
        prevAddr_ff <= progAddr;
        prevData_ff <= progData;
    end
    // Word really executes: PC stepped by one since last cycle, not sleeping
    assign live = progAddr == prevAddr_ff + 15'h1 && !sleeping;

    jump_target_a: assert property (live && progData[13:11] == 3'b101 |=>
        progAddr == {prevAddr_ff[14:11], prevData_ff[10:0]} ##1 $stable(progAddr))
        else $error("jump target or flush wrong");
    kick_flags_a: assert property (live && progData == OPC_KICK |=>
        watchdogKick && timeoutFlag && powerdownFlag) else $error("kick flags wrong");
    sleep_entry_a: assert property (live && progData == OPC_SLEEP |=>
        sleeping && timeoutFlag && !powerdownFlag) else $error("sleep flags wrong");
    option_load_a: assert property (live && progData == OPC_OPTION |=>
        optionValue == $past(accValue)) else $error("option load wrong");
    port_dir_a: assert property (live && progData[13:3] == 11'h00C && progData[2:0] inside {0, 1, 5, 6, 7} |=>
        portDirection[prevData_ff[2:0]] == $past(accValue)) else $error("direction load wrong");
    and_lit_a: assert property (live && progData[13:8] == 6'h39 |=>
        accValue == ($past(accValue) & prevData_ff[7:0]) && zeroFlag == (accValue == 8'h00) && $stable(carryFlag))
        else $error("and literal wrong");
    add_lit_a: assert property (live && progData[13:8] == 6'h3E |=>
        {carryFlag, accValue} == {1'b0, $past(accValue)} + {1'b0, prevData_ff[7:0]}) else $error("add literal wrong");
    ptr_add_a: assert property (live && progData[13:6] == 8'hC4 |=>
        ptr0Value == $past(ptr0Value) + {{10{prevData_ff[5]}}, prevData_ff[5:0]} && $stable(zeroFlag))
        else $error("pointer add wrong");
    stall_write_a: assert property (live && progData[13:2] == 12'h006 && ptr0Value[15] |->
        !dataWrEn ##1 dataWrEn) else $error("stall before write missing");
    int_exit_a: assert property (live && progData == OPC_INT_EXIT |=>
        intEnable ##1 $stable(progAddr)) else $error("interrupt exit wrong");

    cover property (live && progData[13:11] == 3'b101);
    cover property (sleeping);
    cover property (dataWrEn && ptr0Value[15]);
endmodule // cio_core_asserts

bind cio_core cio_core_asserts chk (.sys_clk, .rst, .progAddr, .progData, .dataWrEn, .sleeping, .watchdogKick,
    .intEnable, .accValue, .carryFlag, .zeroFlag, .timeoutFlag, .powerdownFlag, .optionValue, .portDirection, .ptr0Value);

// ---- sim/cio_mem_model.sv ----
/*
 * Program and data memory beside cio_core.
 * Assumes combinational reads and one clock.
 */
`timescale 1ns/100ps
module cio_mem_model (
    // Clock
    input wire logic sys_clk,
    // Core side
    input wire logic [14:0] progAddr,
    output logic [13:0] progData,
    input wire logic [15:0] dataAddr,
    input wire logic dataRdEn,
    input wire logic dataWrEn,
    input wire logic [7:0] dataWrData,
    output logic [7:0] dataRdData
);
    logic [13:0] rom [0:255];
    logic [7:0] ram [0:65535];
    initial for (int i = 0; i < 65536; i++) ram[i] = i[7:0] ^ 8'hA5;
    assign progData = rom[progAddr[7:0]];
    // Unread data shows inverted bits
    assign dataRdData = dataRdEn ? ram[dataAddr] : ~ram[dataAddr];
    always @(posedge sys_clk) if (dataWrEn) ram[dataAddr] <= dataWrData;
endmodule // cio_mem_model

// ---- sim/tb_top.sv ----
/*
 * Self-checking bench for cio_core.
 * Assumes cio_mem_model as memory; wakeUp held low.
 */
`timescale 1ns/100ps
module tb_top;
    import cio_pkg::*;
    logic sys_clk = 0, rst = 1, wakeUp = 0;
    logic [14:0] progAddr;
    logic [13:0] progData;
    logic [15:0] dataAddr, ptr0Value, ptr1Value;
    logic dataRdEn, dataWrEn, sleeping, watchdogKick, softReset, intEnable;
    logic carryFlag, digitCarryFlag, zeroFlag, timeoutFlag, powerdownFlag;
    logic [7:0] dataWrData, dataRdData, accValue, optionValue;
    logic [7:0][7:0] portDirection;
    logic [31:0] lfsr = 32'hD0ED;
    logic [23:0] k;
    logic [9:0] want;
    int bad_count = 0, samples_checked = 0, cycles = 0;

    cio_core DUT (.*);
    cio_mem_model mem (.*);
    always #5 sys_clk = ~sys_clk;

    function automatic logic [31:0] nextRand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Digit carry, carry and sum of an 8-bit add
    function automatic logic [9:0] addExp(input logic [7:0] a, input logic [7:0] b);
        return {({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F, {1'b0, a} + {1'b0, b}};
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] expv);
        samples_checked++;
        if (got !== expv) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, expv);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic restart(input int n);
        @(posedge sys_clk);
        #1 rst = 1;
        tick(1);
        rst = 0;
        tick(n);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            finish_test();
        end
    end

    initial begin
        for (int i = 0; i < 256; i++) mem.rom[i] = OPC_NOP;
        tick(8);
        check(accValue, ACC_RESET);
        check(optionValue, OPTION_RESET);
        check(portDirection[7], PORT_DIR_RESET);
        check(ptr1Value, PTR_RESET);
        check({timeoutFlag, powerdownFlag}, 2'h3);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            lfsr = nextRand(lfsr);
            k = (i == 0) ? 24'hFFF808 : lfsr[23:0];
            mem.rom[0] = OPC_ADD_LIT | {6'h0, k[23:16]};
            mem.rom[1] = OPC_AND_LIT | {6'h0, k[15:8]};
            mem.rom[2] = OPC_ADD_LIT | {6'h0, k[7:0]};
            want = addExp(k[23:16] & k[15:8], k[7:0]);
            restart(3);
            check(accValue, want[7:0]);
            check({digitCarryFlag, carryFlag, zeroFlag}, {want[9:8], want[7:0] == 8'h00});
        end
        $display("literal test done");
        mem.rom[0] = 14'h3145;
        mem.rom[1] = 14'h3120;
        mem.rom[2] = 14'h0016;
        mem.rom[3] = 14'h001B;
        mem.rom[4] = OPC_JUMP | 14'h0008;
        restart(7);
        check(progAddr, 15'h0008);
        check(ptr0Value, 16'hFFDF);
        check(ptr1Value, 16'h0006);
        check({accValue, 7'h00, zeroFlag}, 16'hA000);
        check(mem.ram[16'hFFE0], 8'hA0);
        $display("pointer test done");
        mem.rom[0] = OPC_CALL | 14'h0008;
        mem.rom[1] = OPC_AND_FILE | 14'h00C0;
        mem.rom[2] = OPC_PORT_DIR | 14'h0005;
        mem.rom[3] = OPC_OPTION;
        mem.rom[4] = OPC_KICK;
        mem.rom[5] = OPC_SLEEP;
        mem.rom[8] = OPC_LIT_RETURN | 14'h0077;
        restart(4);
        check(progAddr, 15'h0001);
        check(accValue, 8'h77);
        tick(2);
        check(mem.ram[16'h0040], 8'h65);
        check(portDirection[5], 8'h77);
        tick(1);
        check(optionValue, 8'h77);
        tick(1);
        check({watchdogKick, timeoutFlag, powerdownFlag}, 3'h7);
        tick(1);
        check({sleeping, timeoutFlag, powerdownFlag}, 3'h6);
        $display("call and sleep test done");
        mem.rom[0] = OPC_REL_LIT | 14'h0003;
        mem.rom[4] = OPC_SW_RESET;
        mem.rom[5] = OPC_INT_EXIT;
        restart(2);
        check(progAddr, 15'h0004);
        tick(1);
        check(softReset, 1'b1);
        tick(1);
        check(intEnable, 1'b1);
        $display("branch test done");
        finish_test();
    end
endmodule // tb_top
